/* File: core/sfc_pkg.sv */
package sfc_pkg;
    // register indices (byte address = index * 4)
    localparam logic [23:0] FRAME_COMMAND_IDX = 24'hFFE261;
    localparam logic [23:0] PORT_CONTROL_IDX  = 24'hFFE262;
    localparam logic [23:0] IRQ_STATUS_IDX    = 24'hFFE270;
    localparam logic [23:0] IRQ_MASK_IDX      = 24'hFFE271;
    localparam logic [23:0] LINK_STATUS_IDX   = 24'hFFE272;
    // frame command fields
    localparam int SEL_VALUE_BIT = 0;
    localparam int TX_EOF_BIT    = 1;
    localparam logic [7:0] FRAME_COMMAND_MASK  = 8'h03;
    localparam logic [7:0] FRAME_COMMAND_RESET = 8'h00;
    // port control fields
    localparam int EN_DIR_LO_BIT    = 0;
    localparam int MASTER_EN_BIT    = 1;
    localparam int WIRED_OR_BIT     = 2;
    localparam int CLK_POL_BIT      = 3;
    localparam int PHASE_BIT        = 4;
    localparam int BAUD_GEN_BIT     = 5;
    localparam int EN_DIR_HI_BIT    = 6;
    localparam int DATA_IRQ_EN_BIT  = 7;
    localparam logic [7:0] PORT_CONTROL_RESET = 8'h00;
    // interrupt status layout
    localparam int IRQ_TX_EMPTY  = 0;
    localparam int IRQ_RX_FULL   = 1;
    localparam int IRQ_UNDERRUN  = 2;
    localparam int IRQ_COLLISION = 3;
    localparam int IRQ_ABORT     = 4;
    localparam int IRQ_OVERRUN   = 5;
    localparam int IRQ_FRAME_END = 6;
    localparam logic [7:0] IRQ_VALID_MASK = 8'h7F;
    localparam logic [7:0] IRQ_RESET      = 8'h00;
    // bits per serial byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // enable/direction modes {hi,lo}
    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_RX   = 2'h1,
        MODE_TX   = 2'h2,
        MODE_TXRX = 2'h3
    } sfc_mode_e;
endpackage

/* File: core/sfc_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sfc_edge_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // raw asynchronous level
    input  wire logic asyncIn,
    // synchronised level and edges
    output logic      levelOut,
    output logic      riseOut,
    output logic      fallOut
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;

    // next values: meta only feeds sync
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // two-stage synchroniser plus history
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign levelOut = sync_q;
    assign riseOut  = sync_q & ~prev_q;
    assign fallOut  = ~sync_q & prev_q;
endmodule
`default_nettype wire

/* File: core/sfc_frame_regs.sv */
// Contract
// RQ1: in master mode with select as output, frame command drives select pin.
// RQ2: end-of-frame and select value set by bus writes and by DMA inputs.
// RQ3: frame command bits seven to two read zero, read-only.
// RQ4: end-of-frame bit marks pending transmit byte as the frame's last.
// RQ5: after last byte shifts out, select changes and end-of-frame self-clears; here both hold if dmaEofSync pulses in that same cycle.
// RQ6: end-of-frame zero means not last byte, one means last byte.
// RQ7: with select as output, writing bit zero sets the select pin level.
// RQ8: control register fully read-write, reset zero, with fixed bit layout.
// RQ9: enable/direction bits: 00 off, 01 rx, 10 tx, 11 both.
// RQ10: DMA eof with last byte write sets end-of-frame; after send both clear; here neither clears if dmaEofSync pulses as the byte ends.
// RQ11: clock polarity zero idles clock low, one idles it high.
// RQ12: data irq enable zero blocks data interrupts, errors still interrupt.
// RQ13: writes to reserved frame command bits are ignored.
// RQ14: DMA and bus writing together resolve by one fixed priority.
`timescale 1ns/1ps
`default_nettype none
module sfc_frame_regs
    import sfc_pkg::*;
(
    // system clock and synchronous reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [25:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // dma command inputs, one-cycle strobes
    input  wire logic        dmaSelWr,
    input  wire logic        dmaSelValue,
    input  wire logic        dmaEofSync,
    // status events from the shifter, one-cycle pulses
    input  wire logic        txEmptyEvt,
    input  wire logic        rxFullEvt,
    input  wire logic        underrunEvt,
    input  wire logic        collisionEvt,
    input  wire logic        abortEvt,
    input  wire logic        overrunEvt,
    // select pin direction from mode register
    input  wire logic        selectPinDirection,
    // serial clock from the link, asynchronous
    input  wire logic        sckIn,
    // select pin
    output logic             selectOut,
    output logic             selectOe,
    // decoded control
    output logic [1:0]       modeOut,
    output logic             sckIdleLevel,
    output logic             phaseOut,
    output logic             baudGenControl,
    output logic             wiredOrOut,
    output logic             masterEnable,
    output logic             frameDoneOut,
    // interrupt
    output logic             irqOut
);
    import sfc_pkg::*;

    logic [7:0]  frameCmd_q, frameCmd_d;
    logic [7:0]  portCtl_q, portCtl_d;
    logic [7:0]  irqStat_q, irqStat_d;
    logic [7:0]  irqMask_q, irqMask_d;
    logic [3:0]  bitCnt_q, bitCnt_d;
    logic        ack_q, ack_d;
    logic        err_q, err_d;
    logic [31:0] rdat_q, rdat_d;
    logic        selOut_q, selOut_d;
    logic        selOe_q, selOe_d;
    logic        irq_q, irq_d;
    logic        done_q, done_d;
    logic        sckLevel, sckRise, sckFall;
    logic        sampleEdge;
    logic        byteDone;
    logic        lastByteDone;
    logic        busReq;
    logic        busWr;
    logic        hitFrame, hitCtl, hitStat, hitMask, hitLink, hitAny;
    logic [7:0]  wrByte;
    logic [7:0]  events;
    logic [7:0]  irqGated;

    // match a register index against the word address
    function automatic logic regHit(input logic [25:0] adr,
                                    input logic [23:0] idx);
        regHit = (adr[25:2] == idx) && (adr[1:0] == 2'h0);
    endfunction

    // serial clock crosses through a two-flop synchroniser
    sfc_edge_sync u_sck_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .asyncIn  (sckIn),
        .levelOut (sckLevel),
        .riseOut  (sckRise),
        .fallOut  (sckFall)
    );

    // bus request decode; ack_q and err_q gap ensures one answer per request
    always_comb begin
        busReq   = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
        busWr    = busReq & wb_we_i & wb_sel_i[0];
        hitFrame = regHit(wb_adr_i, FRAME_COMMAND_IDX);
        hitCtl   = regHit(wb_adr_i, PORT_CONTROL_IDX);
        hitStat  = regHit(wb_adr_i, IRQ_STATUS_IDX);
        hitMask  = regHit(wb_adr_i, IRQ_MASK_IDX);
        hitLink  = regHit(wb_adr_i, LINK_STATUS_IDX);
        hitAny   = hitFrame | hitCtl | hitStat | hitMask | hitLink;
        wrByte   = wb_dat_i[7:0];
    end

    // sample edge depends on polarity and phase, 8 edges make a byte
    always_comb begin
        sampleEdge = (portCtl_q[CLK_POL_BIT] ^ portCtl_q[PHASE_BIT])
                     ? sckFall : sckRise; // RQ11
        bitCnt_d = bitCnt_q;
        byteDone = 1'b0;
        if (!selOut_q || !portCtl_q[MASTER_EN_BIT]) begin
            bitCnt_d = 4'h0;
        end else if (sampleEdge) begin
            if (bitCnt_q == BYTE_BITS - 4'h1) begin
                bitCnt_d = 4'h0;
                byteDone = 1'b1;
            end else begin
                bitCnt_d = bitCnt_q + 4'h1;
            end
        end
        lastByteDone = byteDone & frameCmd_q[TX_EOF_BIT]; // RQ4 RQ6
    end

    // frame command next value: dma wins over a bus write, shifter wins last unless dmaEofSync is set
    always_comb begin
        frameCmd_d = frameCmd_q;
        if (busWr && hitFrame) begin
            frameCmd_d = wrByte & FRAME_COMMAND_MASK; // RQ2 RQ7 RQ13
        end
        if (dmaSelWr) begin
            frameCmd_d[SEL_VALUE_BIT] = dmaSelValue; // RQ2 RQ14
        end
        if (dmaEofSync) begin
            frameCmd_d[TX_EOF_BIT] = 1'b1; // RQ10 RQ14
        end
        if (lastByteDone && !dmaEofSync) begin
            // frame closed: deassert select and clear end-of-frame
            frameCmd_d[SEL_VALUE_BIT] = 1'b0; // RQ5 RQ10
            frameCmd_d[TX_EOF_BIT]    = 1'b0; // RQ5
        end
        frameCmd_d[7:2] = 6'h00; // RQ3
    end

    // control register, all bits plain read-write
    always_comb begin
        portCtl_d = portCtl_q;
        if (busWr && hitCtl) begin
            portCtl_d = wrByte; // RQ8
        end
    end

    // events: data interrupts gated by data irq enable, errors never
    always_comb begin
        events = 8'h00;
        events[IRQ_TX_EMPTY]  = txEmptyEvt & portCtl_q[DATA_IRQ_EN_BIT]
                                & portCtl_q[EN_DIR_HI_BIT]; // RQ12 RQ9
        events[IRQ_RX_FULL]   = rxFullEvt & portCtl_q[DATA_IRQ_EN_BIT]
                                & portCtl_q[EN_DIR_LO_BIT]; // RQ12 RQ9
        events[IRQ_UNDERRUN]  = underrunEvt; // RQ12
        events[IRQ_COLLISION] = collisionEvt;
        events[IRQ_ABORT]     = abortEvt;
        events[IRQ_OVERRUN]   = overrunEvt;
        events[IRQ_FRAME_END] = lastByteDone;
        irqStat_d = irqStat_q;
        if (busWr && hitStat) begin
            irqStat_d = irqStat_q & ~wrByte;
        end
        // set wins over a clear in the same cycle
        irqStat_d = (irqStat_d | events) & IRQ_VALID_MASK;
        irqMask_d = irqMask_q;
        if (busWr && hitMask) begin
            irqMask_d = wrByte & IRQ_VALID_MASK;
        end
        irqGated = irqStat_d & irqMask_d;
        irq_d    = |irqGated;
    end

    // select pin: driven from frame command when master and output
    always_comb begin
        selOe_d  = portCtl_d[MASTER_EN_BIT] & selectPinDirection; // RQ1
        // active-high pin: value bit one asserts the select
        selOut_d = frameCmd_d[SEL_VALUE_BIT]; // RQ1 RQ7
        done_d   = lastByteDone;
    end

    // read mux and single-cycle answer; unmapped answers with err
    always_comb begin
        ack_d  = 1'b0;
        err_d  = 1'b0;
        rdat_d = 32'h0000_0000;
        if (busReq) begin
            ack_d = hitAny;
            err_d = ~hitAny;
            if (hitFrame) begin
                rdat_d[7:0] = frameCmd_q & FRAME_COMMAND_MASK; // RQ3
            end else if (hitCtl) begin
                rdat_d[7:0] = portCtl_q;
            end else if (hitStat) begin
                rdat_d[7:0] = irqStat_q;
            end else if (hitMask) begin
                rdat_d[7:0] = irqMask_q;
            end else if (hitLink) begin
                rdat_d[7:0] = {3'h0, bitCnt_q, sckLevel};
            end
        end
    end

    // register everything
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            frameCmd_q <= FRAME_COMMAND_RESET;
            portCtl_q  <= PORT_CONTROL_RESET; // RQ8
            irqStat_q  <= IRQ_RESET;
            irqMask_q  <= IRQ_RESET;
            bitCnt_q   <= 4'h0;
            ack_q      <= 1'b0;
            err_q      <= 1'b0;
            rdat_q     <= 32'h0000_0000;
            selOut_q   <= 1'b0;
            selOe_q    <= 1'b0;
            irq_q      <= 1'b0;
            done_q     <= 1'b0;
        end else begin
            frameCmd_q <= frameCmd_d;
            portCtl_q  <= portCtl_d;
            irqStat_q  <= irqStat_d;
            irqMask_q  <= irqMask_d;
            bitCnt_q   <= bitCnt_d;
            ack_q      <= ack_d;
            err_q      <= err_d;
            rdat_q     <= rdat_d;
            selOut_q   <= selOut_d;
            selOe_q    <= selOe_d;
            irq_q      <= irq_d;
            done_q     <= done_d;
        end
    end

    // outputs straight from flops
    assign wb_dat_o       = rdat_q;
    assign wb_ack_o       = ack_q;
    assign wb_err_o       = err_q;
    assign selectOut      = selOut_q;
    assign selectOe       = selOe_q;
    assign modeOut        = {portCtl_q[EN_DIR_HI_BIT],
                             portCtl_q[EN_DIR_LO_BIT]}; // RQ9
    assign sckIdleLevel   = portCtl_q[CLK_POL_BIT]; // RQ11
    assign phaseOut       = portCtl_q[PHASE_BIT];
    assign baudGenControl = portCtl_q[BAUD_GEN_BIT];
    assign wiredOrOut     = portCtl_q[WIRED_OR_BIT];
    assign masterEnable   = portCtl_q[MASTER_EN_BIT];
    assign frameDoneOut   = done_q;
    assign irqOut         = irq_q;
endmodule
`default_nettype wire

/* File: tb/sfc_frame_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sfc_frame_regs_properties
    import sfc_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [25:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    // dma and pins
    input wire logic        dmaSelWr,
    input wire logic        selectPinDirection,
    input wire logic        selectOut,
    input wire logic        selectOe,
    input wire logic [1:0]  modeOut,
    input wire logic        sckIdleLevel,
    input wire logic        masterEnable,
    input wire logic        frameDoneOut
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // decoded bus phases
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic fcAck = wb_ack_o && wb_adr_i[25:2] == FRAME_COMMAND_IDX;
    wire logic pcAck = wb_ack_o && wb_adr_i[25:2] == PORT_CONTROL_IDX;
    property p_late; req |=> wb_ack_o || wb_err_o; endproperty
    a_late: assert property (p_late) else $error("bus answer late");
    property p_pulse; wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("answer too long");
    property p_excl; !(wb_ack_o && wb_err_o); endproperty
    a_excl: assert property (p_excl) else $error("ack with err");
    property p_rsv; fcAck && !wb_we_i |-> wb_dat_o[31:2] == '0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_ctlWr; pcAck && wb_we_i && wb_sel_i[0] |->
        modeOut == {wb_dat_i[6], wb_dat_i[0]} && sckIdleLevel == wb_dat_i[3]
        && masterEnable == wb_dat_i[1]; endproperty
    a_ctlWr: assert property (p_ctlWr) else $error("ctl write");
    property p_ctlRd; pcAck && !wb_we_i |-> wb_dat_o[3] == sckIdleLevel
        && {wb_dat_o[6], wb_dat_o[0]} == modeOut; endproperty
    a_ctlRd: assert property (p_ctlRd) else $error("ctl read");
    property p_selWr; fcAck && wb_we_i && wb_sel_i[0] && !$past(dmaSelWr)
        |-> selectOut == wb_dat_i[0]; endproperty
    a_selWr: assert property (p_selWr) else $error("select write");
    // enable follows the new master bit and the direction of one cycle ago
    property p_oe; selectOe == (masterEnable && $past(selectPinDirection));
    endproperty
    a_oe: assert property (p_oe) else $error("select enable");
    property p_done; frameDoneOut |=> !frameDoneOut; endproperty
    a_done: assert property (p_done) else $error("done too long");
    // main scenarios reached
    c_wr: cover property (fcAck && wb_we_i);
    c_done: cover property (frameDoneOut);
    c_err: cover property (wb_err_o);
endmodule
`default_nettype wire

/* File: tb/sfc_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side clock: eight 125 ns periods per byte, idle at polarity
module sfc_link_model (
    // start of byte and idle level
    input  wire logic go,
    input  wire logic pol,
    // serial clock
    output logic      sck
);
    logic act;
    assign sck = pol ^ act;
    initial act = 1'b0;
    // clock stands still between bytes
    always @(posedge go) begin
        repeat (8) begin
            #62.5 act = 1'b1;
            #62.5 act = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/spi_frame_command_and_control_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_frame_command_and_control_regs_bench;
    import sfc_pkg::*;
    logic        clk_sys, rst_n, cyc, stb, we, ack, err, selDir, go;
    logic        dmaSelWr, dmaSelValue, dmaEofSync, sck, selectOut;
    logic        selectOe, sckIdleLevel, masterEnable, frameDoneOut, irqOut;
    logic        phaseOut, baudGenControl, wiredOrOut;
    logic [1:0]  modeOut;
    logic [5:0]  ev;
    logic [25:0] adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  r;
    logic        e;
    int          failures, nChecks, cycles;
    sfc_frame_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .dmaSelWr(dmaSelWr), .dmaSelValue(dmaSelValue),
        .dmaEofSync(dmaEofSync), .txEmptyEvt(ev[0]), .rxFullEvt(ev[1]),
        .underrunEvt(ev[2]), .collisionEvt(ev[3]), .abortEvt(ev[4]),
        .overrunEvt(ev[5]), .selectPinDirection(selDir), .sckIn(sck),
        .selectOut(selectOut), .selectOe(selectOe), .modeOut(modeOut),
        .sckIdleLevel(sckIdleLevel), .phaseOut(phaseOut),
        .baudGenControl(baudGenControl),
        .wiredOrOut(wiredOrOut), .masterEnable(masterEnable),
        .frameDoneOut(frameDoneOut), .irqOut(irqOut));
    sfc_link_model link_u (.go(go), .pol(sckIdleLevel), .sck(sck));
    task automatic give_verdict();
        if (failures == 0 && nChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle, released only after the answer edge
    task automatic wbx(input logic w, input logic [23:0] idx,
                       input logic [7:0] d, output logic [7:0] q,
                       output logic er);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h0, d};
        // look at the answer mid-cycle, where it has settled
        do @(negedge clk_sys); while (ack !== 1'b1 && err !== 1'b1);
        q = rdat[7:0];
        er = err;
        // release only after the edge that samples the answer
        @(posedge clk_sys);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [23:0] idx, input logic [7:0] d);
        wbx(1'b1, idx, d, r, e);
    endtask
    task automatic rd(input logic [23:0] idx, input logic [7:0] x);
        wbx(1'b0, idx, 8'h00, r, e);
        chk("read", r, x);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        if (k == 0) dmaSelWr <= 1'b1;
        else dmaEofSync <= 1'b1;
        @(posedge clk_sys);
        dmaSelWr <= 1'b0;
        dmaEofSync <= 1'b0;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // hang guard well above the few hundred cycles needed
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        int t;
        {rst_n, cyc, stb, we, selDir, go, dmaSelWr, dmaSelValue} = '0;
        {dmaEofSync, ev, adr, wdat} = '0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(FRAME_COMMAND_IDX, 8'h00);
        rd(PORT_CONTROL_IDX, 8'h00);
        for (t = 0; t < 4; t++) begin
            wr(PORT_CONTROL_IDX, {1'b0, t[1], 4'h0, 1'b1, t[0]});
            chk("mode", {6'h0, modeOut}, t[7:0]);
        end
        wr(PORT_CONTROL_IDX, 8'hFF);
        rd(PORT_CONTROL_IDX, 8'hFF);
        chk("idle", {7'h0, sckIdleLevel}, 8'h01);
        chk("ctl", {5'h0, phaseOut, baudGenControl, wiredOrOut}, 8'h07);
        wr(PORT_CONTROL_IDX, 8'h42);
        selDir <= 1'b1;
        wr(FRAME_COMMAND_IDX, 8'hFF);
        rd(FRAME_COMMAND_IDX, 8'h03);
        chk("sel", {7'h0, selectOut}, 8'h01);
        chk("oe", {7'h0, selectOe}, 8'h01);
        pulse(0);
        rd(FRAME_COMMAND_IDX, 8'h02);
        wr(FRAME_COMMAND_IDX, 8'h01);
        pulse(1);
        rd(FRAME_COMMAND_IDX, 8'h03);
        // data events blocked, error events still flagged
        @(posedge clk_sys);
        ev <= 6'h3F;
        @(posedge clk_sys);
        ev <= 6'h00;
        rd(IRQ_STATUS_IDX, 8'h3C);
        wr(IRQ_MASK_IDX, 8'h44);
        rd(IRQ_MASK_IDX, 8'h44);
        chk("irq", {7'h0, irqOut}, 8'h01);
        wr(IRQ_STATUS_IDX, 8'h3C);
        rd(IRQ_STATUS_IDX, 8'h00);
        chk("irq", {7'h0, irqOut}, 8'h00);
        // last byte of the frame shifts out
        go <= 1'b1;
        for (t = 0; t < 300 && frameDoneOut !== 1'b1; t++) @(negedge clk_sys);
        chk("done", {7'h0, frameDoneOut}, 8'h01);
        go <= 1'b0;
        rd(FRAME_COMMAND_IDX, 8'h00);
        chk("sel", {7'h0, selectOut}, 8'h00);
        rd(IRQ_STATUS_IDX, 8'h40);
        chk("irq", {7'h0, irqOut}, 8'h01);
        wbx(1'b0, 24'h000000, 8'h00, r, e);
        chk("err", {7'h0, e}, 8'h01);
        give_verdict();
    end
endmodule
bind sfc_frame_regs sfc_frame_regs_properties chk_u (.clk_sys, .rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .dmaSelWr, .selectPinDirection,
    .selectOut, .selectOe, .modeOut, .sckIdleLevel, .masterEnable,
    .frameDoneOut);
`default_nettype wire
